// [rrs_exec.sv]
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module rrs_exec
  import rrs_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire rrs_cmd_t cmd_i,
  output logic cmd_ready_o,
  output logic done_o,
  output rrs_mem_t mem_o,
  input wire logic [7:0] mem_rdata_i,
  input wire rrs_reg_t reg_i,
  output logic [7:0] reg_rdata_o
);

  typedef struct packed {
    rrs_state_t st;
    rrs_kind_t kind;
    rrs_src_t src;
    logic dst_mem;
    logic [3:0] step;
    logic [3:0] last;
    logic [23:0] addr;
    logic [7:0] opnd;
    logic [7:0] res;
    logic [7:0] new_flags;
    logic [7:0] acc;
    logic [7:0] breg;
    logic [7:0] flags;
    logic [15:0] ptr;
    logic [7:0] base_page;
    logic [7:0] exp_page;
    logic paged;
    logic bad_op;
    logic done;
    logic [7:0] rdata;
  } rrs_core_t;

  rrs_core_t st_r;
  rrs_core_t st_nxt;

  // ==========================================================
  // Opcode decode
  function automatic rrs_dec_t decode(input logic [7:0] b0, input logic [7:0] b1);
    rrs_dec_t d;
    d = '{kind: K_NONE, src: S_A, amode: M_NONE, cycles: 4'h1};
    if (b0 == OPC_PREFIX) begin
      case (b1)
        OPC_ROTC_A: d = '{kind: K_ROTC, src: S_A, amode: M_NONE, cycles: CYC_ROT_REG};
        OPC_ROTC_B: d = '{kind: K_ROTC, src: S_B, amode: M_NONE, cycles: CYC_ROT_REG};
        OPC_ROTC_BP: d = '{kind: K_ROTC, src: S_MEM, amode: M_BP, cycles: CYC_ROT_BP};
        OPC_ROTC_PTR: d = '{kind: K_ROTC, src: S_MEM, amode: M_PTR, cycles: CYC_ROT_PTR};
        OPC_CIRC_A: d = '{kind: K_CIRC, src: S_A, amode: M_NONE, cycles: CYC_ROT_REG};
        OPC_CIRC_B: d = '{kind: K_CIRC, src: S_B, amode: M_NONE, cycles: CYC_ROT_REG};
        OPC_CIRC_BP: d = '{kind: K_CIRC, src: S_MEM, amode: M_BP, cycles: CYC_ROT_BP};
        OPC_CIRC_PTR: d = '{kind: K_CIRC, src: S_MEM, amode: M_PTR, cycles: CYC_ROT_PTR};
        default: d = '{kind: K_NONE, src: S_A, amode: M_NONE, cycles: 4'h1};
      endcase
    end else begin
      case (b0)
        OPC_SUB_A: d = '{kind: K_SUB, src: S_A, amode: M_NONE, cycles: CYC_SUB_REG};
        OPC_SUB_B: d = '{kind: K_SUB, src: S_B, amode: M_NONE, cycles: CYC_SUB_REG};
        OPC_SUB_IMM: d = '{kind: K_SUB, src: S_IMM, amode: M_NONE, cycles: CYC_SUB_IMM};
        OPC_SUB_BP: d = '{kind: K_SUB, src: S_MEM, amode: M_BP, cycles: CYC_SUB_BP};
        OPC_SUB_ABS: d = '{kind: K_SUB, src: S_MEM, amode: M_ABS, cycles: CYC_SUB_ABS};
        default: d = '{kind: K_NONE, src: S_A, amode: M_NONE, cycles: 4'h1};
      endcase
    end
    return d;
  endfunction

  // ==========================================================
  // Subtract with borrow: returns {result, N, V, C, Z}
  function automatic logic [11:0] sub_borrow(input logic [7:0] a, input logic [7:0] b, input logic cin,
                                      input logic dec, input logic unp);
    logic [8:0] bin;
    logic [4:0] lo;
    logic [4:0] hi;
    logic lo_bw;
    logic [7:0] r;
    logic cout;
    logic v;
    bin = 9'h000;
    lo = 5'h00;
    hi = 5'h00;
    lo_bw = 1'b0;
    r = 8'h00;
    cout = 1'b0;
    v = 1'b0;
    lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
    lo_bw = lo[4];
    if (dec && lo_bw) begin
      lo = lo - 5'h06;
    end
    hi = {1'b0, a[7:4]} - {1'b0, b[7:4]} - {4'h0, lo_bw};
    if (dec && hi[4]) begin
      hi = hi - 5'h06;
    end
    bin = {1'b0, a} - {1'b0, b} - {8'h00, cin};
    if (unp) begin
      // Unpacked form works on the low digit only
      r = {4'h0, lo[3:0]};
      cout = lo_bw;
    end else if (dec) begin
      r = {hi[3:0], lo[3:0]};
      cout = hi[4];
    end else begin
      r = bin[7:0];
      cout = bin[8];
      v = (a[7] ^ b[7]) & (a[7] ^ r[7]);
    end
    return {r, r[7], v, cout, (r == 8'h00)};
  endfunction

  // ==========================================================
  // Next state
  rrs_dec_t dec;
  logic [11:0] sub_out;
  logic [7:0] rot_res;
  logic rot_c;

  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    dec = decode(cmd_i.op0, cmd_i.op1);
    sub_out = sub_borrow(st_r.acc, st_r.opnd, st_r.flags[FLG_C], st_r.flags[FLG_D], st_r.flags[FLG_U]);
    rot_c = st_r.opnd[0];
    if (st_r.kind == K_CIRC) begin
      rot_res = {st_r.opnd[0], st_r.opnd[7:1]};
    end else begin
      rot_res = {st_r.flags[FLG_C], st_r.opnd[7:1]};
    end

    // Software register writes; a finishing instruction overrides below
    if (reg_i.wr) begin
      case (reg_i.addr)
        REG_ACC: st_nxt.acc = reg_i.wdata;
        REG_BREG: st_nxt.breg = reg_i.wdata;
        REG_FLAGS: st_nxt.flags = reg_i.wdata;
        REG_PTR_LO: st_nxt.ptr[7:0] = reg_i.wdata;
        REG_PTR_HI: st_nxt.ptr[15:8] = reg_i.wdata;
        REG_BASE_PAGE: st_nxt.base_page = reg_i.wdata;
        REG_EXP_PAGE: st_nxt.exp_page = reg_i.wdata;
        REG_CONFIG: st_nxt.paged = reg_i.wdata[CFG_PAGED];
        default: st_nxt.paged = st_nxt.paged;
      endcase
    end
    st_nxt.rdata = RST_BYTE;
    if (reg_i.rd) begin
      case (reg_i.addr)
        REG_ACC: st_nxt.rdata = st_r.acc;
        REG_BREG: st_nxt.rdata = st_r.breg;
        REG_FLAGS: st_nxt.rdata = st_r.flags;
        REG_PTR_LO: st_nxt.rdata = st_r.ptr[7:0];
        REG_PTR_HI: st_nxt.rdata = st_r.ptr[15:8];
        REG_BASE_PAGE: st_nxt.rdata = st_r.base_page;
        REG_EXP_PAGE: st_nxt.rdata = st_r.exp_page;
        REG_CONFIG: st_nxt.rdata = {7'h00, st_r.paged};
        REG_STATUS: st_nxt.rdata = {6'h00, st_r.bad_op, (st_r.st == ST_EXEC)};
        default: st_nxt.rdata = RST_BYTE;
      endcase
    end

    case (st_r.st)
      ST_IDLE: begin
        if (cmd_i.valid) begin
          if (dec.kind == K_NONE) begin
            // Unknown opcodes are dropped and flagged, no done pulse
            st_nxt.bad_op = 1'b1;
          end else begin
            st_nxt.bad_op = 1'b0;
            st_nxt.st = ST_EXEC;
            st_nxt.kind = dec.kind;
            st_nxt.src = dec.src;
            st_nxt.dst_mem = (dec.src == S_MEM) && (dec.kind != K_SUB);
            st_nxt.step = 4'h0;
            st_nxt.last = 4'(dec.cycles * CLK_PER_CYC - 1);
            // Page byte is zero outside the paged models
            st_nxt.addr[23:16] = st_r.paged ? st_r.exp_page : 8'h00;
            case (dec.amode)
              M_PTR: st_nxt.addr[15:0] = st_r.ptr;
              M_BP: st_nxt.addr[15:0] = {st_r.base_page, cmd_i.lo};
              M_ABS: st_nxt.addr[15:0] = {cmd_i.hi, cmd_i.lo};
              default: st_nxt.addr[15:0] = 16'h0000;
            endcase
            case (dec.src)
              S_A: st_nxt.opnd = st_r.acc;
              S_B: st_nxt.opnd = st_r.breg;
              S_IMM: st_nxt.opnd = cmd_i.lo;
              default: st_nxt.opnd = RST_BYTE;
            endcase
          end
        end
      end
      ST_EXEC: begin
        st_nxt.step = st_r.step + 4'h1;
        if (st_r.step == 4'h1 && st_r.src == S_MEM) begin
          st_nxt.opnd = mem_rdata_i;
        end
        if (st_r.step == st_r.last - 4'h1) begin
          st_nxt.new_flags = st_r.flags;
          if (st_r.kind == K_SUB) begin
            st_nxt.res = sub_out[11:4];
            st_nxt.new_flags[FLG_N] = sub_out[3];
            st_nxt.new_flags[FLG_V] = sub_out[2];
            st_nxt.new_flags[FLG_C] = sub_out[1];
            st_nxt.new_flags[FLG_Z] = sub_out[0];
          end else begin
            st_nxt.res = rot_res;
            st_nxt.new_flags[FLG_N] = rot_res[7];
            st_nxt.new_flags[FLG_C] = rot_c;
            st_nxt.new_flags[FLG_Z] = (rot_res == 8'h00);
          end
        end
        if (st_r.step == st_r.last) begin
          st_nxt.st = ST_IDLE;
          st_nxt.done = 1'b1;
          st_nxt.flags = st_r.new_flags;
          if (st_r.kind == K_SUB || st_r.src == S_A) begin
            if (!st_r.dst_mem) begin
              st_nxt.acc = (st_r.kind == K_SUB || st_r.src == S_A) ? st_r.res : st_r.acc;
            end
          end
          if (st_r.kind != K_SUB && st_r.src == S_B) begin
            st_nxt.breg = st_r.res;
          end
        end
      end
      default: st_nxt.st = ST_IDLE;
    endcase
  end

  // ==========================================================
  // State register
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '{st: ST_IDLE, kind: K_NONE, src: S_A, addr: 24'h000000, ptr: RST_PTR, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Outputs; address held for the whole instruction
  assign cmd_ready_o = (st_r.st == ST_IDLE);
  assign done_o = st_r.done;
  assign reg_rdata_o = st_r.rdata;
  assign mem_o.addr = st_r.addr;
  assign mem_o.wdata = st_r.res;
  assign mem_o.rd = (st_r.st == ST_EXEC) && (st_r.step == 4'h0) && (st_r.src == S_MEM);
  assign mem_o.wr = (st_r.st == ST_EXEC) && (st_r.step == st_r.last) && st_r.dst_mem;

endmodule

// [rrs_pkg.sv]
package rrs_pkg;

  // ==========================================================
  // Opcodes
  localparam logic [7:0] OPC_PREFIX = 8'hCE;
  localparam logic [7:0] OPC_SUB_A = 8'h18;
  localparam logic [7:0] OPC_SUB_B = 8'h19;
  localparam logic [7:0] OPC_SUB_IMM = 8'h1A;
  localparam logic [7:0] OPC_SUB_BP = 8'h1D;
  localparam logic [7:0] OPC_SUB_ABS = 8'h1F;
  localparam logic [7:0] OPC_ROTC_A = 8'h98;
  localparam logic [7:0] OPC_ROTC_B = 8'h99;
  localparam logic [7:0] OPC_ROTC_BP = 8'h9A;
  localparam logic [7:0] OPC_ROTC_PTR = 8'h9B;
  localparam logic [7:0] OPC_CIRC_A = 8'h9C;
  localparam logic [7:0] OPC_CIRC_B = 8'h9D;
  localparam logic [7:0] OPC_CIRC_BP = 8'h9E;
  localparam logic [7:0] OPC_CIRC_PTR = 8'h9F;

  // ==========================================================
  // Timing, in instruction cycles of two clocks each
  localparam int CLK_PER_CYC = 2;
  localparam logic [3:0] CYC_SUB_REG = 4'h2;
  localparam logic [3:0] CYC_SUB_IMM = 4'h2;
  localparam logic [3:0] CYC_SUB_BP = 4'h3;
  localparam logic [3:0] CYC_SUB_ABS = 4'h4;
  localparam logic [3:0] CYC_ROT_REG = 4'h3;
  localparam logic [3:0] CYC_ROT_BP = 4'h5;
  localparam logic [3:0] CYC_ROT_PTR = 4'h4;

  // ==========================================================
  // Software register map
  localparam logic [3:0] REG_ACC = 4'h0;
  localparam logic [3:0] REG_BREG = 4'h1;
  localparam logic [3:0] REG_FLAGS = 4'h2;
  localparam logic [3:0] REG_PTR_LO = 4'h3;
  localparam logic [3:0] REG_PTR_HI = 4'h4;
  localparam logic [3:0] REG_BASE_PAGE = 4'h5;
  localparam logic [3:0] REG_EXP_PAGE = 4'h6;
  localparam logic [3:0] REG_CONFIG = 4'h7;
  localparam logic [3:0] REG_STATUS = 4'h8;

  // Flag byte, config and status bit layout
  localparam int FLG_Z = 0;
  localparam int FLG_C = 1;
  localparam int FLG_V = 2;
  localparam int FLG_N = 3;
  localparam int FLG_D = 4;
  localparam int FLG_U = 5;
  localparam int CFG_PAGED = 0;
  localparam int STS_BUSY = 0;
  localparam int STS_BAD_OP = 1;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_PTR = 16'h0000;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC} rrs_state_t;
  typedef enum logic [1:0] {K_NONE, K_ROTC, K_CIRC, K_SUB} rrs_kind_t;
  typedef enum logic [1:0] {S_A, S_B, S_IMM, S_MEM} rrs_src_t;
  typedef enum logic [1:0] {M_NONE, M_PTR, M_BP, M_ABS} rrs_amode_t;

  typedef struct packed {
    rrs_kind_t kind;
    rrs_src_t src;
    rrs_amode_t amode;
    logic [3:0] cycles;
  } rrs_dec_t;

  typedef struct packed {
    logic valid;
    logic [7:0] op0;
    logic [7:0] op1;
    logic [7:0] lo;
    logic [7:0] hi;
  } rrs_cmd_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [23:0] addr;
    logic [7:0] wdata;
  } rrs_mem_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rrs_reg_t;

endpackage

// [rrs_mem_model.sv]
`timescale 1ns/1ps
module rrs_mem_model
  import rrs_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire rrs_mem_t mem_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [logic [23:0]];
  // Idle data line inverts every cycle, so it alternates between the inverse and a stale copy of the last byte
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else begin
      if (mem_i.rd) begin
        rdata_o <= mem.exists(mem_i.addr) ? mem[mem_i.addr] : 8'hA5;
      end else begin
        rdata_o <= ~rdata_o;
      end
      if (mem_i.wr) begin
        mem[mem_i.addr] = mem_i.wdata;
      end
    end
  end
endmodule

// [rrs_exec_sva.sv]
`timescale 1ns/1ps
module rrs_exec_chk
  import rrs_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire rrs_cmd_t cmd_i,
  input wire logic cmd_ready_o,
  input wire logic done_o,
  input wire rrs_mem_t mem_o,
  input wire logic [7:0] mem_rdata_i,
  input wire rrs_reg_t reg_i,
  input wire logic [7:0] reg_rdata_o
);
  logic [7:0] op_r, lo_r, rd_r, bp_r, xpg_r, cfg_r, pg;
  logic [15:0] ptr_r;
  logic [23:0] ra_r;
  logic [4:0] cnt_r;
  logic pf_r, rs_r, acc;
  assign acc = cmd_i.valid && cmd_ready_o;
  assign pg = cfg_r[0] ? xpg_r : 8'h00;
  // ==========================
  // Shadow of the page registers and of the running instruction
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      {op_r, lo_r, rd_r, bp_r, xpg_r, cfg_r, ptr_r, ra_r, cnt_r, pf_r, rs_r} <= '0;
    end else begin
      cnt_r <= acc ? 5'h00 : cnt_r + 5'h01;
      if (acc) begin
        pf_r <= cmd_i.op0 == OPC_PREFIX;
        op_r <= (cmd_i.op0 == OPC_PREFIX) ? cmd_i.op1 : cmd_i.op0;
        lo_r <= cmd_i.lo;
      end
      if (reg_i.wr && reg_i.addr == REG_PTR_LO) ptr_r[7:0] <= reg_i.wdata;
      if (reg_i.wr && reg_i.addr == REG_PTR_HI) ptr_r[15:8] <= reg_i.wdata;
      if (reg_i.wr && reg_i.addr == REG_BASE_PAGE) bp_r <= reg_i.wdata;
      if (reg_i.wr && reg_i.addr == REG_EXP_PAGE) xpg_r <= reg_i.wdata;
      if (reg_i.wr && reg_i.addr == REG_CONFIG) cfg_r <= reg_i.wdata;
      rs_r <= mem_o.rd;
      if (mem_o.rd) ra_r <= mem_o.addr;
      if (rs_r) rd_r <= mem_rdata_i;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // ==========================
  // Assertions
  property p_circ_bp_t; done_o && pf_r && op_r == OPC_CIRC_BP |-> cnt_r inside {5'h09, 5'h0A}; endproperty
  a_circ_bp_t: assert property (p_circ_bp_t) else $error("base-page rotate length");
  property p_circ_ptr_t; done_o && pf_r && op_r == OPC_CIRC_PTR |-> cnt_r inside {5'h07, 5'h08}; endproperty
  a_circ_ptr_t: assert property (p_circ_ptr_t) else $error("pointer rotate length");
  property p_sub_reg_t; done_o && !pf_r && op_r[7:1] == 7'h0C |-> cnt_r inside {5'h03, 5'h04}; endproperty
  a_sub_reg_t: assert property (p_sub_reg_t) else $error("register subtract length");
  property p_sub_imm_t; done_o && !pf_r && op_r == OPC_SUB_IMM |-> cnt_r inside {5'h03, 5'h04}; endproperty
  a_sub_imm_t: assert property (p_sub_imm_t) else $error("immediate subtract length");
  property p_sub_abs_t; done_o && !pf_r && op_r == OPC_SUB_ABS |-> cnt_r inside {5'h07, 5'h08}; endproperty
  a_sub_abs_t: assert property (p_sub_abs_t) else $error("absolute subtract length");
  property p_rmw; mem_o.wr |-> mem_o.addr == ra_r && $past(cmd_ready_o, 2) == 1'b0; endproperty
  a_rmw: assert property (p_rmw) else $error("write address moved");
  property p_circ_wd; mem_o.wr && pf_r && op_r[2:1] == 2'b11 |-> mem_o.wdata == {rd_r[0], rd_r[7:1]}; endproperty
  a_circ_wd: assert property (p_circ_wd) else $error("circular rotate data");
  property p_ptr_a; mem_o.rd && pf_r && op_r[1:0] == 2'b11 |-> mem_o.addr == {pg, ptr_r}; endproperty
  a_ptr_a: assert property (p_ptr_a) else $error("pointer address");
  property p_bp_a; mem_o.rd && (pf_r ? op_r[1:0] == 2'b10 : op_r == OPC_SUB_BP) |-> mem_o.addr == {pg, bp_r, lo_r};
  endproperty
  a_bp_a: assert property (p_bp_a) else $error("base-page address");
  c_ptr: cover property (done_o && pf_r && op_r == OPC_CIRC_PTR);
  c_bp: cover property (done_o && !pf_r && op_r == OPC_SUB_BP);
  c_paged: cover property (mem_o.rd && mem_o.addr[23:16] != 8'h00);
endmodule
bind rrs_exec rrs_exec_chk u_chk (.ref_clk_i, .rst_i, .cmd_i, .cmd_ready_o, .done_o, .mem_o, .mem_rdata_i, .reg_i,
  .reg_rdata_o);

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top
  import rrs_pkg::*;
();
  logic ref_clk_i, rst_i, cmd_ready_o, done_o, tc;
  logic rdp = 1'b0;
  rrs_cmd_t cmd_i;
  rrs_mem_t mem_o;
  rrs_reg_t reg_i;
  logic [7:0] mem_rdata_i, reg_rdata_o, tv;
  logic [31:0] seed = 32'h3035F81D;
  logic [7:0] rq[$];
  logic [31:0] wq[$];
  int miscompares = 0, n_checks = 0, cyc = 0;
  logic [7:0] av[4] = '{8'hA8, 8'h36, 8'h88, 8'h88}, bv[4] = '{8'h42, 8'h5A, 8'h39, 8'h39};
  logic [7:0] fi[4] = '{8'h02, 8'h02, 8'h12, 8'h32}, ra[4] = '{8'h65, 8'hDB, 8'h48, 8'h08};
  logic [7:0] rf[4] = '{8'h04, 8'h0A, 8'h10, 8'h32}, vv[5] = '{8'h7E, 8'h51, 8'hD4, 8'hC6, 8'hD7};
  logic [7:0] ops[4] = '{OPC_SUB_B, OPC_SUB_IMM, OPC_SUB_BP, OPC_SUB_ABS};
  logic [4:0] vc = 5'b01100;
  rrs_exec uut (.ref_clk_i, .rst_i, .cmd_i, .cmd_ready_o, .done_o, .mem_o, .mem_rdata_i, .reg_i, .reg_rdata_o);
  rrs_mem_model u_mem (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .mem_i(mem_o), .rdata_o(mem_rdata_i));
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string what);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, g, e);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ==========================
  // Bus drivers; a gap cycle keeps each strobe a single pulse
  task automatic acc(input logic [3:0] a, input logic [7:0] d, input logic w);
    if (!w) rq.push_back(d);
    reg_i <= '{a, d, w, !w};
    @(posedge ref_clk_i);
    reg_i <= '0;
    @(posedge ref_clk_i);
  endtask
  task automatic ex(input logic [7:0] o0, input logic [7:0] o1, input logic [7:0] l, input logic [7:0] h);
    int i = 0;
    cmd_i <= '{1'b1, o0, o1, l, h};
    @(posedge ref_clk_i);
    cmd_i.valid <= 1'b0;
    do begin
      @(posedge ref_clk_i);
      i++;
    end while (done_o !== 1'b1 && i < 30);
    if (i >= 30) chk(32'h0, 32'h1, "no done");
  endtask
  task automatic sub_case(input int k, input int j);
    logic [7:0] l, h;
    l = rnd();
    h = rnd();
    acc(REG_ACC, av[j], 1'b1);
    acc(REG_FLAGS, fi[j], 1'b1);
    case (k)
      0: acc(REG_BREG, bv[j], 1'b1);
      2: u_mem.mem[{8'h5A, 8'h12, l}] = bv[j];
      3: u_mem.mem[{8'h5A, h, l}] = bv[j];
      default: l = bv[j];
    endcase
    ex(ops[k], 8'h00, l, h);
    acc(REG_ACC, ra[j], 1'b0);
    acc(REG_FLAGS, rf[j], 1'b0);
  endtask
  task automatic rot(input logic [7:0] o1, input logic [7:0] v, input logic c, input logic [7:0] pg);
    logic [7:0] r, l;
    l = rnd();
    r = {o1[2] ? v[0] : c, v[7:1]};
    acc(REG_FLAGS, {4'h3, 1'b0, 1'b1, c, 1'b0}, 1'b1);
    case (o1[1:0])
      2'd0: acc(REG_ACC, v, 1'b1);
      2'd1: acc(REG_BREG, v, 1'b1);
      2'd2: u_mem.mem[{pg, 8'h12, l}] = v;
      default: u_mem.mem[{pg, 16'hC034}] = v;
    endcase
    if (o1[1]) wq.push_back({o1[0] ? {pg, 16'hC034} : {pg, 8'h12, l}, r});
    ex(OPC_PREFIX, o1, l, 8'h00);
    if (!o1[1]) acc(o1[0] ? REG_BREG : REG_ACC, r, 1'b0);
    acc(REG_FLAGS, {4'h3, r[7], 1'b1, v[0], r == 8'h00}, 1'b0);
  endtask
  // ==========================
  // Result watcher
  always @(posedge ref_clk_i) begin
    cyc++;
    if (rdp) chk(reg_rdata_o, rq.pop_front(), "read");
    rdp = reg_i.rd;
    if (mem_o.wr) chk({mem_o.addr, mem_o.wdata}, wq.pop_front(), "write");
    if (cyc > 20000) begin
      chk(32'h0, 32'h1, "timeout");
      finish_test();
    end
  end
  initial begin
    rst_i = 1'b1;
    cmd_i = '0;
    reg_i = '0;
    repeat (4) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    acc(REG_ACC, RST_BYTE, 1'b0);
    acc(REG_EXP_PAGE, 8'h5A, 1'b1);
    acc(REG_BASE_PAGE, 8'h12, 1'b1);
    acc(REG_PTR_LO, 8'h34, 1'b1);
    acc(REG_PTR_HI, 8'hC0, 1'b1);
    acc(4'hC, 8'h00, 1'b0);
    acc(REG_CONFIG, 8'h01, 1'b1);
    for (int k = 0; k < 4; k++) begin
      for (int j = 0; j < 4; j++) sub_case(k, j);
    end
    // Unknown prefixed opcode: flagged in status, no done pulse
    cmd_i <= '{1'b1, OPC_PREFIX, 8'h00, 8'h00, 8'h00};
    @(posedge ref_clk_i);
    cmd_i.valid <= 1'b0;
    acc(REG_STATUS, 8'h02, 1'b0);
    acc(REG_ACC, rnd(), 1'b1);
    acc(REG_FLAGS, 8'h02, 1'b1);
    ex(OPC_SUB_A, 8'h00, 8'h00, 8'h00);
    acc(REG_ACC, 8'hFF, 1'b0);
    acc(REG_FLAGS, 8'h0A, 1'b0);
    acc(REG_STATUS, 8'h00, 1'b0);
    $display("subtract tests done");
    for (int p = 0; p < 2; p++) begin
      acc(REG_CONFIG, {7'h00, p == 0}, 1'b1);
      for (int o = 0; o < 8; o++) begin
        for (int i = 0; i < 7; i++) begin
          tv = (i < 5) ? vv[i] : (i == 5) ? 8'h00 : rnd();
          tc = (i < 5) ? vc[i] : seed[9];
          rot(OPC_ROTC_A + 8'(o), tv, tc, (p == 0) ? 8'h5A : 8'h00);
        end
      end
    end
    $display("rotate tests done");
    finish_test();
  end
endmodule
